// [inc/mcls_params.svh]
// register map, field positions, reset values and counts of the modem control block
`ifndef MCLS_PARAMS_SVH
`define MCLS_PARAMS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_TX_HOLD    4'h0
`define IDX_IRQ_EN     4'h1
`define IDX_IRQ_ID     4'h2
`define IDX_MODEM_CTL  4'h4
`define IDX_LINE_STAT  4'h5
`define IDX_CONFIG     4'h8
`define IDX_NONE       4'hf

// ----------------------------------------------------------------
// modem_control fields
// ----------------------------------------------------------------
`define MC_DTR         0
`define MC_RTS         1
`define MC_OUT1        2
`define MC_IRQ_DRIVE   3
`define MC_USED_MASK   8'h1f
`define MC_RESET       8'h00

// ----------------------------------------------------------------
// line_status fields
// ----------------------------------------------------------------
`define LS_DR          0
`define LS_OE          1
`define LS_PE          2
`define LS_FE          3
`define LS_BI          4
`define LS_TX_HOLDING_EMPTY        5
`define LS_TRANSMITTER_IDLE        6
`define LS_FIFO_ERR    7

// ----------------------------------------------------------------
// interrupt enable, interrupt id and config fields
// ----------------------------------------------------------------
`define IE_TX_HOLDING_EMPTY        1
`define IE_LINE        2
`define IE_MASK        8'h06
`define IE_RESET       8'h00
`define IID_NONE       8'h01
`define IID_LINE       8'h06
`define IID_TX_HOLDING_EMPTY       8'h02
`define CFG_FIFO       0
`define CFG_MASK       8'h01
`define CFG_RESET      8'h00

// ----------------------------------------------------------------
// break detection: two characters plus three bit times
// ----------------------------------------------------------------
`define BRK_CHARS      6'd2
`define BRK_EXTRA_BITS 6'd3

`endif

// [inc/mcls_pkg.sv]
// types shared by the modem control / line status block
package mcls_pkg;

   // ----------------------------------------------------------------
   // bus sequencing states (gray along idle -> access)
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      BUS_IDLE   = 2'b00,
      BUS_ACCESS = 2'b01
   } bus_st_e;

   // transmit side status from the serial datapath
   typedef struct packed {
      logic fifo_empty;   // transmit fifo holds no byte
      logic shift_busy;   // shift register holds a character
      logic load_done;    // pulse: holding buffer moved to shifter
   } tx_status_s;

   // receive side status from the serial datapath
   typedef struct packed {
      logic data_ready;   // receive buffer holds data
      logic overrun;      // pulse: overrun seen
      logic parity_err;   // pulse: parity error seen
      logic framing_err;  // pulse: framing error seen
      logic fifo_err;     // level: fifo holds an errored character
   } rx_status_s;

   // byte handed to the transmitter
   typedef struct packed {
      logic       write;  // pulse: new byte for holding buffer
      logic [7:0] data;   // byte written by the host
   } tx_req_s;

   // break detector state
   typedef struct packed {
      logic [5:0] cnt;    // bit times spent at space
      logic       fired;  // break already reported
      logic       pulse;  // one-cycle break report
   } brk_state_s;

   // whole state of the register block
   typedef struct packed {
      bus_st_e     st;
      logic [3:0]  idx;        // captured register index
      logic        wr;         // captured direction
      logic        ready;      // hreadyout
      logic [31:0] rdata;      // hrdata
      logic [7:0]  mc;         // modem_control
      logic [7:0]  ie;         // interrupt enable
      logic [7:0]  cfg;        // fifo mode config
      tx_req_s     tx;         // byte to transmitter
      logic        tx_holding_empty;       // tx_holding_empty
      logic        oe;
      logic        pe;
      logic        fe;
      logic        bi;         // break_detected
      logic        fifo_err;
      logic        tx_holding_empty_irq;   // pending holding-empty interrupt
      logic        irq;        // host_irq_out value
      logic [1:0]  rxd_sync;   // receive pin synchroniser
   } mcls_state_s;

endpackage : mcls_pkg

// [verilog/break_detector.sv]
// break detector: reports a receive line held at space too long
`include "mcls_params.svh"

module break_detector
   import mcls_pkg::*;
(
   // clock and reset
   input  wire logic       hclk,
   input  wire logic       hresetn,
   // line and timing
   input  wire logic       rxd_level,   // synchronised receive level
   input  wire logic       bit_tick,    // one pulse per bit time
   input  wire logic [3:0] char_bits,   // bits per character frame
   // report
   output logic            brk_pulse    // one cycle per break
);

   brk_state_s s_q;   // registered state
   brk_state_s s_d;   // next state
   logic [5:0] limit; // bit times that must be exceeded

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d       = s_q;
      s_d.pulse = 1'b0;
      limit     = `BRK_CHARS * {2'b00, char_bits} + `BRK_EXTRA_BITS;
      if (rxd_level) begin
         // mark ends the break and rearms
         s_d.cnt   = 6'h00;
         s_d.fired = 1'b0;
      end else if (bit_tick && !s_q.fired) begin
         if (s_q.cnt == limit) begin
            s_d.pulse = 1'b1;
            s_d.fired = 1'b1;
         end else begin
            s_d.cnt = s_q.cnt + 6'h01;
         end
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign brk_pulse = s_q.pulse;

endmodule : break_detector

// [verilog/modem_ctrl_line_status.sv]
// modem control and line status registers behind an ahb-lite slave
//
// Our own choice: register access over AHB-Lite.
`include "mcls_params.svh"

// Notes on behaviour
// - control bit 3 drives or floats irq
// - control bit 1 sets request-to-send
// - control bit 0 sets data-terminal-ready
// - status bit 7 zero outside fifo mode
// - fifo error bit; read clears if none
// - transmitter idle: holding and shifter empty
// - fifo mode: idle when fifo, shifter empty
// - holding empty: set on move, cleared by write
// - fifo mode: holding empty follows fifo empty
// - enabled holding empty raises host interrupt
// - break: space over two chars plus three
// - status read clears break bit
// - line errors raise top priority interrupt
// - id read or buffer write clears holding-empty interrupt
module modem_ctrl_line_status
   import mcls_pkg::*;
(
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // serial datapath status
   input  wire tx_status_s  tx_st,
   input  wire rx_status_s  rx_st,
   input  wire logic        bit_tick,
   input  wire logic [3:0]  char_bits,
   output tx_req_s          tx_req,
   // pins
   input  wire logic        rxd,
   output logic             rts_out,
   output logic             dtr_out,
   output logic             host_irq_out,
   output logic             host_irq_oe_n
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   mcls_state_s s_q;        // registered state
   mcls_state_s s_d;        // next state
   logic        brk_pulse;  // break report from detector
   logic        do_rd;      // read takes effect this cycle
   logic        do_wr;      // write takes effect this cycle
   logic        thr_write;  // host wrote the holding buffer
   logic        ls_read;    // host read line status
   logic        iid_read;   // host read interrupt id
   logic        ie_write;   // host wrote interrupt enable
   logic        fifo_mode;  // fifo mode selected
   logic        transmitter_idle;       // transmitter idle
   logic        ls_pend;    // line status interrupt pending
   logic [7:0]  ls_val;     // line status read value
   logic [7:0]  iid_val;    // interrupt id read value
   logic [7:0]  rd_val;     // selected read byte

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------

   // true when an access of the given kind hits an index
   function automatic logic hit(input logic act, input logic [3:0] idx,
                                input logic [3:0] target);
      hit = act && (idx == target);
   endfunction : hit

   // ----------------------------------------------------------------
   // break detection on the synchronised receive line
   // ----------------------------------------------------------------
   break_detector u_brk (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .rxd_level (s_q.rxd_sync[1]),
      .bit_tick  (bit_tick),
      .char_bits (char_bits),
      .brk_pulse (brk_pulse)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d          = s_q;
      s_d.tx.write = 1'b0;
      // first stage feeds only the second
      s_d.rxd_sync = {s_q.rxd_sync[0], rxd};
      do_rd        = 1'b0;
      do_wr        = 1'b0;

      // bus sequencing: one wait state so hrdata comes from a flop
      case (s_q.st)
         BUS_IDLE: begin
            s_d.ready = 1'b1;
            if (hsel && htrans[1] && hready) begin
               s_d.st    = BUS_ACCESS;
               s_d.wr    = hwrite;
               s_d.ready = 1'b0;
               // upper address bits must be clear to hit a register
               if (haddr[31:6] == 26'h0 && haddr[1:0] == 2'b00) begin
                  s_d.idx = haddr[5:2];
               end else begin
                  s_d.idx = `IDX_NONE;
               end
            end
         end
         BUS_ACCESS: begin
            // access completes, data phase ends next edge
            s_d.st    = BUS_IDLE;
            s_d.ready = 1'b1;
            do_rd     = ~s_q.wr;
            do_wr     = s_q.wr;
         end
         default: begin
            s_d.st    = BUS_IDLE;
            s_d.ready = 1'b1;
         end
      endcase

      // decoded accesses
      thr_write = hit(do_wr, s_q.idx, `IDX_TX_HOLD);
      ie_write  = hit(do_wr, s_q.idx, `IDX_IRQ_EN);
      ls_read   = hit(do_rd, s_q.idx, `IDX_LINE_STAT);
      iid_read  = hit(do_rd, s_q.idx, `IDX_IRQ_ID);
      fifo_mode = s_q.cfg[`CFG_FIFO];

      // holding-empty flag
      if (fifo_mode) begin
         s_d.tx_holding_empty = tx_st.fifo_empty;
      end else begin
         s_d.tx_holding_empty = tx_st.load_done | (s_q.tx_holding_empty & ~thr_write);
      end

      // transmitter idle, derived not stored
      if (fifo_mode) begin
         transmitter_idle = tx_st.fifo_empty & ~tx_st.shift_busy;
      end else begin
         transmitter_idle = s_q.tx_holding_empty & ~tx_st.shift_busy;
      end

      // sticky receive errors: an event in the clearing cycle wins
      s_d.oe = rx_st.overrun | (s_q.oe & ~ls_read);
      s_d.pe = rx_st.parity_err | (s_q.pe & ~ls_read);
      s_d.fe = rx_st.framing_err | (s_q.fe & ~ls_read);
      s_d.bi = brk_pulse | (s_q.bi & ~ls_read);
      s_d.fifo_err = fifo_mode & (rx_st.fifo_err | (s_q.fifo_err & ~ls_read));

      // line status value seen by a read
      ls_val               = 8'h00;
      ls_val[`LS_DR]       = rx_st.data_ready;
      ls_val[`LS_OE]       = s_q.oe;
      ls_val[`LS_PE]       = s_q.pe;
      ls_val[`LS_FE]       = s_q.fe;
      ls_val[`LS_BI]       = s_q.bi;
      ls_val[`LS_TX_HOLDING_EMPTY]     = s_q.tx_holding_empty;
      ls_val[`LS_TRANSMITTER_IDLE]     = transmitter_idle;
      ls_val[`LS_FIFO_ERR] = s_q.fifo_err & fifo_mode;

      ls_pend = s_q.ie[`IE_LINE] & (s_q.oe | s_q.pe | s_q.fe | s_q.bi);

      // interrupt id, line status ahead of holding empty
      if (ls_pend) begin
         iid_val = `IID_LINE;
      end else if (s_q.tx_holding_empty_irq) begin
         iid_val = `IID_TX_HOLDING_EMPTY;
      end else begin
         iid_val = `IID_NONE;
      end

      // holding-empty interrupt: set on rising empty or on enabling
      if ((s_q.ie[`IE_TX_HOLDING_EMPTY] && s_d.tx_holding_empty && !s_q.tx_holding_empty) ||
          (ie_write && hwdata[`IE_TX_HOLDING_EMPTY] && !s_q.ie[`IE_TX_HOLDING_EMPTY] && s_q.tx_holding_empty)) begin
         s_d.tx_holding_empty_irq = 1'b1;
      end else if (iid_read || thr_write || !s_q.ie[`IE_TX_HOLDING_EMPTY]) begin
         s_d.tx_holding_empty_irq = 1'b0;
      end

      // read mux
      case (s_q.idx)
         `IDX_IRQ_EN:    rd_val = s_q.ie;
         `IDX_IRQ_ID:    rd_val = iid_val;
         `IDX_MODEM_CTL: rd_val = s_q.mc & `MC_USED_MASK;
         `IDX_LINE_STAT: rd_val = ls_val;
         `IDX_CONFIG:    rd_val = s_q.cfg;
         default:        rd_val = 8'h00;
      endcase
      if (do_rd) begin
         s_d.rdata = {24'h000000, rd_val};
      end

      // register writes; line status ignores writes
      if (do_wr) begin
         case (s_q.idx)
            `IDX_TX_HOLD: begin
               s_d.tx.data  = hwdata[7:0];
               s_d.tx.write = 1'b1;
            end
            `IDX_IRQ_EN: begin
               s_d.ie = hwdata[7:0] & `IE_MASK;
            end
            `IDX_MODEM_CTL: begin
               s_d.mc = hwdata[7:0] & `MC_USED_MASK;
            end
            `IDX_CONFIG: begin
               s_d.cfg = hwdata[7:0] & `CFG_MASK;
            end
            `IDX_LINE_STAT: begin
               s_d.mc = s_q.mc;
            end
            default: begin
               s_d.cfg = s_q.cfg;
            end
         endcase
      end

      // interrupt line value from next-state flags
      s_d.irq = (s_d.ie[`IE_LINE] & (s_d.oe | s_d.pe | s_d.fe | s_d.bi)) |
                s_d.tx_holding_empty_irq;
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q          <= '0;
         s_q.st       <= BUS_IDLE;
         s_q.ready    <= 1'b1;
         s_q.idx      <= `IDX_NONE;
         s_q.mc       <= `MC_RESET;
         s_q.ie       <= `IE_RESET;
         s_q.cfg      <= `CFG_RESET;
         s_q.tx_holding_empty     <= 1'b1;
         s_q.rxd_sync <= 2'b11;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs from flops (host_irq_oe_n through an inverter), hresp tied low
   // ----------------------------------------------------------------
   assign hrdata        = s_q.rdata;
   assign hreadyout     = s_q.ready;
   assign hresp         = 1'b0;
   assign tx_req        = s_q.tx;
   assign rts_out       = s_q.mc[`MC_RTS];
   assign dtr_out       = s_q.mc[`MC_DTR];
   assign host_irq_out  = s_q.irq;
   assign host_irq_oe_n = ~s_q.mc[`MC_IRQ_DRIVE];

endmodule : modem_ctrl_line_status

// [dv/mcls_properties.sv]
// concurrent checks on the ports of the modem control block
`include "mcls_params.svh"

module mcls_properties
   import mcls_pkg::*;
(
   // clock and reset
   input wire logic        hclk,
   input wire logic        hresetn,
   // ahb-lite slave
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   // datapath and pins
   input wire tx_status_s  tx_st,
   input wire rx_status_s  rx_st,
   input wire tx_req_s     tx_req,
   input wire logic        rts_out,
   input wire logic        dtr_out,
   input wire logic        host_irq_out,
   input wire logic        host_irq_oe_n
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // ----
   // transfer tracking
   // ----
   logic       ph_q;   // data phase pending
   logic       wr_q;   // captured direction
   logic [3:0] ix_q;   // captured index
   logic [7:0] ie_q;   // copy of interrupt enable
   logic       ff_q;   // copy of fifo mode
   logic       done;   // access takes effect at this edge, data phase ends next edge
   logic       err_ev; // any receive error pulse

   assign done   = ph_q && !hreadyout;
   assign err_ev = rx_st.overrun || rx_st.parity_err || rx_st.framing_err;

   // true when a transfer of this kind takes effect at this edge
   function automatic logic acc(input logic w, input logic [3:0] i);
      return done && wr_q == w && ix_q == i;
   endfunction : acc

   // capture each address phase and mirror enable and mode writes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_q <= 1'b0;
         wr_q <= 1'b0;
         ix_q <= 4'h0;
         ie_q <= 8'h00;
         ff_q <= 1'b0;
      end else begin
         if (hsel && htrans[1] && hready) begin
            ph_q <= 1'b1;
            wr_q <= hwrite;
            ix_q <= (haddr[31:6] == 26'h0 && haddr[1:0] == 2'h0) ? haddr[5:2] : `IDX_NONE;
         end else if (done) begin
            ph_q <= 1'b0;
         end
         if (acc(1'b1, `IDX_IRQ_EN))
            ie_q <= hwdata[7:0];
         if (acc(1'b1, `IDX_CONFIG))
            ff_q <= hwdata[0];
      end
   end

   // ----
   // assertions
   // ----
   // drive follows bit 3
   irq_drive_a: assert property (acc(1'b1, `IDX_MODEM_CTL)
      |=> host_irq_oe_n == !$past(hwdata[3])) else $error("irq enable wrong after write");
   irq_hold_a: assert property (!$stable(host_irq_oe_n)
      |-> $past(acc(1'b1, `IDX_MODEM_CTL))) else $error("irq enable moved without write");
   rts_dtr_a: assert property (acc(1'b1, `IDX_MODEM_CTL)
      |=> {rts_out, dtr_out} == $past(hwdata[1:0])) else $error("rts or dtr wrong");
   one_wait_a: assert property (hsel && htrans[1] && hready
      |=> !hreadyout ##1 hreadyout) else $error("transfer not one wait state");
   ctl_zero_a: assert property (acc(1'b0, `IDX_MODEM_CTL)
      |=> hrdata[31:5] == 27'h0) else $error("control upper bits not zero");
   // bit 7 zero outside fifo mode
   fifo_bit_a: assert property (acc(1'b0, `IDX_LINE_STAT) && !ff_q
      |=> !hrdata[7]) else $error("status bit 7 set outside fifo mode");
   line_irq_a: assert property (err_ev && ie_q[2]
      |-> ##[1:3] host_irq_out) else $error("line error gave no interrupt");
   id_clear_a: assert property (acc(1'b0, `IDX_IRQ_ID) && !ie_q[2] && !tx_st.load_done
      |-> ##2 !host_irq_out) else $error("id read left interrupt up");
   tx_push_a: assert property (acc(1'b1, `IDX_TX_HOLD)
      |=> tx_req.write && tx_req.data == $past(hwdata[7:0]) ##1 !tx_req.write)
      else $error("holding write not passed on");
   tx_only_a: assert property (tx_req.write
      |-> $past(acc(1'b1, `IDX_TX_HOLD))) else $error("stray transmit pulse");

   cover property (acc(1'b1, `IDX_TX_HOLD));
   cover property (err_ev && ie_q[2]);
   cover property (acc(1'b0, `IDX_LINE_STAT) && ff_q);
endmodule : mcls_properties

bind modem_ctrl_line_status mcls_properties mcls_properties_i (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
   .hreadyout(hreadyout), .tx_st(tx_st), .rx_st(rx_st), .tx_req(tx_req),
   .rts_out(rts_out), .dtr_out(dtr_out), .host_irq_out(host_irq_out),
   .host_irq_oe_n(host_irq_oe_n)
);

// [dv/serial_far_end.sv]
// far-end model: serial transmitter, bit clock and receive line
module serial_far_end
   import mcls_pkg::*;
#(
   parameter int TICK  = 4,  // clocks per bit time
   parameter int SHIFT = 8   // clocks a character spends shifting
)
(
   // clock and reset
   input wire logic    hclk,
   input wire logic    hresetn,
   // bench control
   input wire logic    stall,     // keep bytes waiting
   input wire logic    line_low,  // hold the receive line at space
   // datapath
   input wire tx_req_s tx_req,
   output tx_status_s  tx_st,
   output logic        bit_tick,
   output logic        rxd
);
   timeunit 1ns;
   timeprecision 1ps;

   int   cnt;   // bytes waiting to be shifted
   int   sh;    // clocks left on the shifter
   int   div;   // bit time divider
   logic ld_q;  // load pulse

   // bytes queue on each write and leave one at a time unless stalled
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt  <= 0;
         sh   <= 0;
         div  <= 0;
         ld_q <= 1'b0;
      end else begin
         div  <= (div == TICK - 1) ? 0 : div + 1;
         ld_q <= 1'b0;
         if (sh > 0)
            sh <= sh - 1;
         if (cnt > 0 && sh == 0 && !ld_q && !stall) begin
            ld_q <= 1'b1;
            sh   <= SHIFT;
            cnt  <= cnt - 1 + int'(tx_req.write);
         end else begin
            cnt <= cnt + int'(tx_req.write);
         end
      end
   end

   // empty, busy while a load or shift runs, load pulse
   assign tx_st    = {cnt == 0, sh > 0 || ld_q, ld_q};
   assign bit_tick = (div == TICK - 1);
   // line idles high like a stop bit
   assign rxd      = !line_low;
endmodule : serial_far_end

// [dv/modem_ctrl_line_status_tb.sv]
// self-checking bench for the modem control and line status block
`include "mcls_params.svh"

module modem_ctrl_line_status_tb
   import mcls_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        hclk     = 1'b0;
   logic        hresetn  = 1'b0;
   logic        hsel     = 1'b0;
   logic [31:0] haddr    = 32'h0;
   logic [1:0]  htrans   = 2'h0;
   logic        hwrite   = 1'b0;
   logic [31:0] hwdata   = 32'h0;
   rx_status_s  rx_st    = '0;
   logic        stall    = 1'b0;
   logic        line_low = 1'b0;
   logic [31:0] hrdata;
   logic        hreadyout;
   tx_status_s  tx_st;
   tx_req_s     tx_req;
   logic        bit_tick;
   logic        rxd;
   logic        rts_out;
   logic        dtr_out;
   logic        host_irq_out;
   logic        host_irq_oe_n;
   logic [31:0] rd;
   int          fails    = 0;
   int          compares = 0;
   logic [7:0]  mcv [5]  = '{8'hff, 8'h0a, 8'h05, 8'h04, 8'h00};

   // clock at 40 mhz
   always #12.5 hclk = ~hclk;

   modem_ctrl_line_status modem_ctrl_line_status_i (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(), .tx_st(tx_st), .rx_st(rx_st), .bit_tick(bit_tick),
      .char_bits(4'ha), .tx_req(tx_req), .rxd(rxd), .rts_out(rts_out), .dtr_out(dtr_out),
      .host_irq_out(host_irq_out), .host_irq_oe_n(host_irq_oe_n)
   );

   serial_far_end serial_far_end_i (
      .hclk(hclk), .hresetn(hresetn), .stall(stall), .line_low(line_low),
      .tx_req(tx_req), .tx_st(tx_st), .bit_tick(bit_tick), .rxd(rxd)
   );

   // ----
   // tasks
   // ----
   task automatic final_report();
      $display("counts: compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : final_report

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic idle(input int n);
      repeat (n) @(posedge hclk);
   endtask : idle

   // wait for hready high at a rising edge, bounded
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin
         chk(hreadyout, 32'h1);
         final_report();
      end
   endtask : wait_rdy

   // one single word transfer: address phase, then data phase
   task automatic bus(input logic w, input logic [3:0] ix, input logic [7:0] wd);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr  <= {26'h0, ix, 2'h0};
      wait_rdy();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      wait_rdy();
      rd = hrdata;
   endtask : bus

   task automatic wr(input logic [3:0] ix, input logic [7:0] wd);
      bus(1'b1, ix, wd);
   endtask : wr

   task automatic rdchk(input logic [3:0] ix, input logic [31:0] exp);
      bus(1'b0, ix, 8'h00);
      chk(rd, exp);
   endtask : rdchk

   // ----
   // tests
   // ----
   initial begin
      idle(6);
      hresetn <= 1'b1;
      idle(1);
      rdchk(`IDX_MODEM_CTL, 32'h0);
      rdchk(`IDX_LINE_STAT, 32'h60);
      chk(host_irq_oe_n, 32'h1);
      foreach (mcv[i]) begin
         wr(`IDX_MODEM_CTL, mcv[i]);
         chk(host_irq_oe_n, {31'h0, ~mcv[i][3]});
         chk({rts_out, dtr_out}, {30'h0, mcv[i][1:0]});
         rdchk(`IDX_MODEM_CTL, {24'h0, mcv[i] & 8'h1f});
      end
      wr(`IDX_LINE_STAT, 8'hff);
      rdchk(`IDX_LINE_STAT, 32'h60);
      rdchk(`IDX_NONE, 32'h0);
      $display("test registers done");
      // holding write with the transmitter stalled
      stall <= 1'b1;
      wr(`IDX_MODEM_CTL, 8'h08);
      wr(`IDX_TX_HOLD, 8'ha5);
      chk(tx_req.data, 32'ha5);
      rdchk(`IDX_LINE_STAT, 32'h00);
      wr(`IDX_IRQ_EN, 8'h02);
      stall <= 1'b0;
      idle(3);
      rdchk(`IDX_LINE_STAT, 32'h20);
      idle(20);
      rdchk(`IDX_LINE_STAT, 32'h60);
      chk(host_irq_out, 32'h1);
      rdchk(`IDX_IRQ_ID, 32'h02);
      idle(2);
      chk(host_irq_out, 32'h0);
      rdchk(`IDX_IRQ_ID, 32'h01);
      $display("test transmit done");
      // overrun, parity and framing pulses in turn
      wr(`IDX_IRQ_EN, 8'h04);
      for (int i = 0; i < 3; i++) begin
         rx_st <= 5'(5'h08 >> i);
         idle(1);
         rx_st <= '0;
         idle(3);
         chk(host_irq_out, 32'h1);
         rdchk(`IDX_IRQ_ID, 32'h06);
         rdchk(`IDX_LINE_STAT, 32'h60 | (32'h2 << i));
         idle(2);
         chk(host_irq_out, 32'h0);
      end
      $display("test line errors done");
      // errored character waiting, then fifo mode
      rx_st <= 5'h11;
      idle(1);
      rdchk(`IDX_LINE_STAT, 32'h61);
      wr(`IDX_CONFIG, 8'h01);
      rdchk(`IDX_LINE_STAT, 32'he1);
      rdchk(`IDX_LINE_STAT, 32'he1);
      rx_st <= '0;
      idle(1);
      rdchk(`IDX_LINE_STAT, 32'he0);
      rdchk(`IDX_LINE_STAT, 32'h60);
      stall <= 1'b1;
      wr(`IDX_TX_HOLD, 8'h11);
      wr(`IDX_TX_HOLD, 8'h22);
      rdchk(`IDX_LINE_STAT, 32'h00);
      stall <= 1'b0;
      idle(3);
      rdchk(`IDX_LINE_STAT, 32'h00);
      idle(40);
      rdchk(`IDX_LINE_STAT, 32'h60);
      $display("test fifo mode done");
      // short space, then a space long enough for a break
      line_low <= 1'b1;
      idle(88);
      line_low <= 1'b0;
      idle(8);
      rdchk(`IDX_LINE_STAT, 32'h60);
      line_low <= 1'b1;
      idle(108);
      rdchk(`IDX_LINE_STAT, 32'h70);
      rdchk(`IDX_LINE_STAT, 32'h60);
      line_low <= 1'b0;
      $display("test break done");
      final_report();
   end
endmodule : modem_ctrl_line_status_tb
